// [include/adc_corr_pkg.sv]
// constants, types and carriers shared by the ADC correction stage
//
// Operation
// - internal conversion path always yields a 24-bit signed bipolar raw value
// - unipolar conversion and amplifier gain are applied digitally after correction
// - offset correction resets to 00_0000, gain correction to 80_0000 (unity)
// - unipolar mode clamps negative results to zero and adds a factor of two
// - digital gain comes from the two-bit amplifier gain setting field
// - self offset calibration shorts the inputs and stores the raw value as offset
// - self gain calibration applies reference, gain becomes reciprocal of raw minus offset
// - selected self calibration runs unaided, stores results and uses them afterwards
// - system calibration uses host-applied zero and full scale; device stores results
// - offset correction is a 24-bit two's complement number
// - gain correction is unsigned with one integer and 23 fraction bits
// - data register changes only when a new conversion completes
// - temperature sensor selected by positive select 0111 and negative select 0000
// - unipolar results are straight binary, bipolar results two's complement
// - unipolar range 0..65535, bipolar range -32768..+32767
`default_nettype none
package adc_corr_pkg;
  // ----------------------------------------------------------------
  // widths and fixed-point positions
  // ----------------------------------------------------------------
  localparam int RAW_W = 24;
  localparam int OUT_W = 16;
  localparam int GAIN_FRAC = 23;
  localparam int OUT_SHIFT = 8;
  localparam int QUOT_W = 48;
  localparam int RECIP_EXP = 46;
  localparam int DIV_CYCLES_MAX = 60;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [23:0] OFFSET_RESET = 24'h00_0000;
  localparam logic [23:0] GAIN_RESET = 24'h80_0000;
  localparam logic [23:0] GAIN_MAX = 24'hFF_FFFF;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic signed [33:0] UNI_MAX = 34'sh0_0000_FFFF;
  localparam logic signed [33:0] BIP_MAX = 34'sh0_0000_7FFF;
  localparam logic signed [33:0] BIP_MIN = 34'sh3_FFFF_8000;
  localparam logic [3:0] TEMP_POS_SEL = 4'h7;
  localparam logic [3:0] TEMP_NEG_SEL = 4'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CAL_SELF_OFFSET = 2'h0,
    CAL_SELF_GAIN = 2'h1,
    CAL_SYS_OFFSET = 2'h2,
    CAL_SYS_GAIN = 2'h3
  } cal_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_DIVIDE = 3'b100
  } cal_state_t;

  typedef struct packed {
    logic [1:0] amplifier_gain_setting;
    logic unipolar;
    logic [3:0] positive_input_select;
    logic [3:0] negative_input_select;
  } conv_cfg_t;

  typedef struct packed {
    logic input_short;
    logic ref_to_input;
    logic temp_sensor_en;
    logic [3:0] positive_input_select;
    logic [3:0] negative_input_select;
  } analog_ctl_t;
endpackage
`default_nettype wire

// [src/recip_divider.sv]
// sequential restoring divider forming 2**NUM_EXP / divisor
`timescale 1ns/10ps
`default_nettype none
module recip_divider #(
  parameter int DIV_W = 24,
  parameter int QUOT_W = 48,
  parameter int NUM_EXP = 46
) (
  input wire logic clk_i, // system clock
  input wire logic rstn_i, // async reset, active low
  input wire logic ce_i, // clock enable
  input wire logic start_i, // start pulse
  input wire logic [DIV_W-1:0] divisor_i, // divisor, zero gives all ones
  output logic busy_o, // division running
  output logic done_o, // one-cycle pulse, quotient valid
  output logic [QUOT_W-1:0] quotient_o // quotient register
);
  localparam int CNT_W = $clog2(QUOT_W + 1);

  logic [DIV_W-1:0] rem, next_rem, div, next_div;
  logic [QUOT_W-1:0] next_quot;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_busy, next_done;
  logic [DIV_W:0] trial;
  logic ge;

  // ----------------------------------------------------------------
  // one quotient bit per cycle; the numerator is a single set bit
  // ----------------------------------------------------------------
  always_comb begin
    next_rem = rem;
    next_div = div;
    next_quot = quotient_o;
    next_cnt = cnt;
    next_busy = busy_o;
    next_done = 1'b0;
    trial = {rem, (cnt == CNT_W'(NUM_EXP + 1))};
    ge = (trial >= {1'b0, div});
    if (start_i) begin
      next_rem = '0;
      next_div = divisor_i;
      next_quot = '0;
      next_cnt = CNT_W'(QUOT_W);
      next_busy = 1'b1;
    end else if (busy_o) begin
      next_rem = ge ? DIV_W'(trial - {1'b0, div}) : trial[DIV_W-1:0];
      next_quot = {quotient_o[QUOT_W-2:0], ge};
      next_cnt = cnt - CNT_W'(1);
      if (cnt == CNT_W'(1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rem <= '0;
      div <= '0;
      quotient_o <= '0;
      cnt <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      rem <= next_rem;
      div <= next_div;
      quotient_o <= next_quot;
      cnt <= next_cnt;
      busy_o <= next_busy;
      done_o <= next_done;
    end
  end

  a_div_finishes: assert property (@(posedge clk_i) disable iff (!rstn_i || !ce_i)
    start_i |=> busy_o ##48 done_o)
    else $error("divider did not finish in 48 cycles");
endmodule // recip_divider
`default_nettype wire

// [src/adc_correction.sv]
// offset/gain correction and calibration sequencer of the sigma-delta converter
`timescale 1ns/10ps
`default_nettype none
module adc_correction (
  input wire logic REF_CLK_I, // 100 MHz clock
  input wire logic RSTN_I, // async reset, active low
  input wire logic CE_I, // clock enable, freezes all state when low
  input wire logic RAW_VALID_I, // decimation filter result strobe
  input wire logic [23:0] RAW_DATA_I, // 24-bit signed raw result
  input wire adc_corr_pkg::conv_cfg_t CONV_CFG_I, // gain, polarity, input selects
  input wire logic CAL_START_I, // start calibration pulse
  input wire adc_corr_pkg::cal_mode_t CAL_MODE_I, // calibration kind
  input wire logic OFFSET_WR_I, // write offset correction
  input wire logic GAIN_WR_I, // write gain correction
  input wire logic [23:0] CORR_WDATA_I, // correction write data
  output logic [23:0] OFFSET_CORR_O, // offset correction register
  output logic [23:0] GAIN_CORR_O, // gain correction register
  output logic [15:0] DATA_O, // conversion result register
  output logic DATA_VALID_O, // one-cycle pulse, new result
  output logic CAL_BUSY_O, // calibration in progress
  output adc_corr_pkg::analog_ctl_t ANALOG_CTL_O // analog front-end control
);
  // ----------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic signed [24:0] raw_minus_offset(input logic [23:0] raw,
                                                         input logic [23:0] off);
    raw_minus_offset = $signed({raw[23], raw}) - $signed({off[23], off});
  endfunction

  function automatic logic signed [33:0] corr_scale(input logic signed [24:0] diff,
                                                    input logic [23:0] gain,
                                                    input logic [1:0] amp);
    logic signed [49:0] prod;
    logic signed [33:0] s;
    prod = diff * $signed({1'b0, gain});
    s = 34'(prod >>> adc_corr_pkg::GAIN_FRAC);
    corr_scale = s <<< amp;
  endfunction

  function automatic logic [15:0] sat_out(input logic signed [33:0] v, input logic uni);
    logic signed [33:0] u;
    u = uni ? (v >>> (adc_corr_pkg::OUT_SHIFT - 1)) : (v >>> adc_corr_pkg::OUT_SHIFT);
    if (uni) begin
      if (v < 0) sat_out = 16'h0000;
      else if (u > adc_corr_pkg::UNI_MAX) sat_out = 16'hFFFF;
      else sat_out = u[15:0];
    end else begin
      if (u > adc_corr_pkg::BIP_MAX) sat_out = 16'h7FFF;
      else if (u < adc_corr_pkg::BIP_MIN) sat_out = 16'h8000;
      else sat_out = u[15:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  adc_corr_pkg::cal_state_t cal_state, next_cal_state;
  adc_corr_pkg::cal_mode_t cal_mode, next_cal_mode;
  logic [23:0] next_offset, next_gain;
  logic [15:0] next_data;
  logic next_data_valid;
  logic div_start;
  logic [23:0] div_divisor;
  logic div_busy, div_done;
  logic [47:0] div_quot;
  logic signed [24:0] diff;
  logic signed [33:0] scaled;
  logic conv_fire;
  logic self_mode, offset_mode;

  // raw path is always bipolar 24-bit; polarity only matters at the output
  assign diff = raw_minus_offset(RAW_DATA_I, OFFSET_CORR_O);
  assign scaled = corr_scale(diff, GAIN_CORR_O, CONV_CFG_I.amplifier_gain_setting);
  // conversions that land during calibration are never published; only the sample phase uses one
  assign conv_fire = RAW_VALID_I && (cal_state == adc_corr_pkg::ST_IDLE);
  assign self_mode = (cal_mode == adc_corr_pkg::CAL_SELF_OFFSET) ||
                     (cal_mode == adc_corr_pkg::CAL_SELF_GAIN);
  assign offset_mode = (cal_mode == adc_corr_pkg::CAL_SELF_OFFSET) ||
                       (cal_mode == adc_corr_pkg::CAL_SYS_OFFSET);

  // ----------------------------------------------------------------
  // calibration sequencer and correction registers
  // ----------------------------------------------------------------
  always_comb begin
    next_cal_state = cal_state;
    next_cal_mode = cal_mode;
    next_offset = OFFSET_CORR_O;
    next_gain = GAIN_CORR_O;
    div_start = 1'b0;
    div_divisor = '0;
    if (OFFSET_WR_I) next_offset = CORR_WDATA_I;
    if (GAIN_WR_I) next_gain = CORR_WDATA_I;
    case (cal_state)
      adc_corr_pkg::ST_IDLE: begin
        if (CAL_START_I) begin
          next_cal_mode = CAL_MODE_I;
          next_cal_state = adc_corr_pkg::ST_SAMPLE;
        end
      end
      adc_corr_pkg::ST_SAMPLE: begin
        if (RAW_VALID_I) begin
          if (offset_mode) begin
            // calibration result beats a host write in the same cycle
            next_offset = RAW_DATA_I;
            next_cal_state = adc_corr_pkg::ST_IDLE;
          end else begin
            // non-positive span cannot be inverted: divisor 0 saturates the gain
            div_divisor = (diff > 0) ? diff[23:0] : 24'h00_0000;
            div_start = 1'b1;
            next_cal_state = adc_corr_pkg::ST_DIVIDE;
          end
        end
      end
      adc_corr_pkg::ST_DIVIDE: begin
        if (div_done) begin
          next_gain = (div_quot > 48'(adc_corr_pkg::GAIN_MAX)) ?
                      adc_corr_pkg::GAIN_MAX : div_quot[23:0];
          next_cal_state = adc_corr_pkg::ST_IDLE;
        end
      end
      default: next_cal_state = adc_corr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cal_state <= adc_corr_pkg::ST_IDLE;
      cal_mode <= adc_corr_pkg::CAL_SELF_OFFSET;
      OFFSET_CORR_O <= adc_corr_pkg::OFFSET_RESET;
      GAIN_CORR_O <= adc_corr_pkg::GAIN_RESET;
    end else if (CE_I) begin
      cal_state <= next_cal_state;
      cal_mode <= next_cal_mode;
      OFFSET_CORR_O <= next_offset;
      GAIN_CORR_O <= next_gain;
    end
  end

  recip_divider #(
    .DIV_W(adc_corr_pkg::RAW_W),
    .QUOT_W(adc_corr_pkg::QUOT_W),
    .NUM_EXP(adc_corr_pkg::RECIP_EXP)
  ) u_recip (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .start_i(div_start),
    .divisor_i(div_divisor),
    .busy_o(div_busy),
    .done_o(div_done),
    .quotient_o(div_quot)
  );

  // ----------------------------------------------------------------
  // data register: only a completed conversion moves it
  // ----------------------------------------------------------------
  always_comb begin
    next_data = DATA_O;
    next_data_valid = 1'b0;
    if (conv_fire) begin
      next_data = sat_out(scaled, CONV_CFG_I.unipolar);
      next_data_valid = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      DATA_O <= adc_corr_pkg::DATA_RESET;
      DATA_VALID_O <= 1'b0;
    end else if (CE_I) begin
      DATA_O <= next_data;
      DATA_VALID_O <= next_data_valid;
    end
  end

  // ----------------------------------------------------------------
  // analog front-end control
  // ----------------------------------------------------------------
  always_comb begin
    ANALOG_CTL_O.positive_input_select = CONV_CFG_I.positive_input_select;
    ANALOG_CTL_O.negative_input_select = CONV_CFG_I.negative_input_select;
    ANALOG_CTL_O.input_short = (cal_state == adc_corr_pkg::ST_SAMPLE) &&
                               (cal_mode == adc_corr_pkg::CAL_SELF_OFFSET);
    ANALOG_CTL_O.ref_to_input = (cal_state == adc_corr_pkg::ST_SAMPLE) &&
                                (cal_mode == adc_corr_pkg::CAL_SELF_GAIN);
    ANALOG_CTL_O.temp_sensor_en =
      (CONV_CFG_I.positive_input_select == adc_corr_pkg::TEMP_POS_SEL) &&
      (CONV_CFG_I.negative_input_select == adc_corr_pkg::TEMP_NEG_SEL) &&
      !(ANALOG_CTL_O.input_short || ANALOG_CTL_O.ref_to_input);
  end

  assign CAL_BUSY_O = (cal_state != adc_corr_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_data_holds: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    !(CE_I && conv_fire) |=> $stable(DATA_O))
    else $error("data register moved without a conversion");

  a_result_strobe: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (CE_I && conv_fire) |=> DATA_VALID_O && (DATA_O == $past(next_data)))
    else $error("conversion result not registered");

  a_uni_clamp: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (CE_I && conv_fire && CONV_CFG_I.unipolar && scaled < 0) |=> DATA_O == 16'h0000)
    else $error("negative unipolar result not clamped");

  a_bip_saturate: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (CE_I && conv_fire && !CONV_CFG_I.unipolar &&
     (scaled >>> adc_corr_pkg::OUT_SHIFT) > adc_corr_pkg::BIP_MAX) |=> DATA_O == 16'h7FFF)
    else $error("bipolar overflow not saturated");

  a_self_offset: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (CE_I && ANALOG_CTL_O.input_short && RAW_VALID_I) |=>
    (OFFSET_CORR_O == $past(RAW_DATA_I)) && !CAL_BUSY_O)
    else $error("self offset result not stored");

  a_short_inputs: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (cal_state == adc_corr_pkg::ST_SAMPLE && cal_mode == adc_corr_pkg::CAL_SELF_OFFSET)
    |-> ANALOG_CTL_O.input_short && !ANALOG_CTL_O.ref_to_input)
    else $error("inputs not shorted during self offset");

  a_cal_ends: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I || !CE_I)
    (cal_state == adc_corr_pkg::ST_DIVIDE) |-> ##[1:60] (cal_state == adc_corr_pkg::ST_IDLE))
    else $error("gain calibration did not complete");

  a_temp_select: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    ANALOG_CTL_O.temp_sensor_en |->
    (ANALOG_CTL_O.positive_input_select == 4'h7) && (ANALOG_CTL_O.negative_input_select == 4'h0))
    else $error("temperature sensor enabled on wrong selects");

  a_gain_span: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (CE_I && cal_state == adc_corr_pkg::ST_DIVIDE && div_done) |=>
    (GAIN_CORR_O == (($past(div_quot) > 48'h00_00FF_FFFF) ? 24'hFF_FFFF : $past(div_quot[23:0])))
    && !CAL_BUSY_O)
    else $error("gain calibration result not stored");

  // the sequencer must never sit in the divide phase with the divider idle
  a_divider_runs: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (cal_state == adc_corr_pkg::ST_DIVIDE) |-> (div_busy || div_done))
    else $error("gain calibration waiting on an idle divider");
endmodule // adc_correction
`default_nettype wire

// [dv/raw_source.sv]
// far-side model: analog front end and decimation filter delivering raw results
`timescale 1ns/10ps
`default_nettype none
module raw_source #(
  parameter logic [23:0] SHORT_RAW = 24'h00_0123, // residual code with inputs shorted
  parameter logic [23:0] REF_RAW = 24'h40_1000 // code with the reference on the input
) (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset, active low
  input wire logic req_i, // deliver one result on the next cycle
  input wire logic [23:0] ext_i, // code of the external input
  input wire adc_corr_pkg::analog_ctl_t ctl_i, // front-end switch settings
  output logic valid_o, // result strobe
  output logic [23:0] data_o // raw result
);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid_o <= 1'b0;
      data_o <= 24'h00_0000;
    end else if (req_i) begin
      valid_o <= 1'b1;
      data_o <= ctl_i.input_short ? SHORT_RAW : (ctl_i.ref_to_input ? REF_RAW : ext_i);
    end else begin
      valid_o <= 1'b0;
      data_o <= ~data_o; // stale data is never held, so a late sample shows up
    end
  end
endmodule // raw_source
`default_nettype wire

// [dv/adc_calibration_correction_test.sv]
// self-checking bench of the correction and calibration stage
`timescale 1ns/10ps
`default_nettype none
module adc_calibration_correction_test;
  localparam logic [23:0] SHORT_V = 24'h00_0123;
  localparam logic [23:0] REF_V = 24'h40_1000;
  logic ref_clk, rstn, cal_start, off_wr, gain_wr, req, raw_valid, data_valid, cal_busy;
  logic [23:0] wdata, ext, raw, e_off, e_gain, offset_corr, gain_corr;
  logic [15:0] data, held;
  adc_corr_pkg::conv_cfg_t cfg;
  adc_corr_pkg::cal_mode_t mode;
  adc_corr_pkg::analog_ctl_t actl;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;

  adc_correction i_adc_correction (.REF_CLK_I(ref_clk), .RSTN_I(rstn), .CE_I(1'b1),
    .RAW_VALID_I(raw_valid), .RAW_DATA_I(raw), .CONV_CFG_I(cfg), .CAL_START_I(cal_start),
    .CAL_MODE_I(mode), .OFFSET_WR_I(off_wr), .GAIN_WR_I(gain_wr), .CORR_WDATA_I(wdata),
    .OFFSET_CORR_O(offset_corr), .GAIN_CORR_O(gain_corr), .DATA_O(data),
    .DATA_VALID_O(data_valid), .CAL_BUSY_O(cal_busy), .ANALOG_CTL_O(actl));
  raw_source #(.SHORT_RAW(SHORT_V), .REF_RAW(REF_V)) i_raw_source (.clk_i(ref_clk),
    .rstn_i(rstn), .req_i(req), .ext_i(ext), .ctl_i(actl), .valid_o(raw_valid), .data_o(raw));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // the whole run needs about 210 cycles
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
    check_count = check_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  function automatic logic [15:0] exp_conv(input logic [23:0] r);
    longint v;
    v = (longint'($signed(r)) - longint'($signed(e_off))) * longint'(e_gain);
    v = (v >>> 23) <<< cfg.amplifier_gain_setting;
    if (cfg.unipolar) begin
      v = v >>> 7;
      v = (v < 0) ? 0 : ((v > 65535) ? 65535 : v);
    end else begin
      v = v >>> 8;
      v = (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
    end
    return v[15:0];
  endfunction

  task automatic conv(input logic [23:0] r);
    int i;
    @(posedge ref_clk);
    req <= 1'b1;
    ext <= r;
    @(posedge ref_clk);
    req <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      #1;
      if (data_valid === 1'b1) break;
    end
    chk(i[23:0], 24'h00_0000, "latency");
    chk({8'h00, data}, {8'h00, exp_conv(r)}, "result");
  endtask

  task automatic wr(input logic g, input logic [23:0] v);
    @(posedge ref_clk);
    gain_wr <= g;
    off_wr <= !g;
    wdata <= v;
    @(posedge ref_clk);
    gain_wr <= 1'b0;
    off_wr <= 1'b0;
    #1;
    if (g) e_gain = v;
    else e_off = v;
    chk(g ? gain_corr : offset_corr, v, "write");
  endtask

  task automatic cal(input adc_corr_pkg::cal_mode_t m, input logic [23:0] v);
    logic signed [63:0] d;
    logic [63:0] q;
    logic [23:0] s;
    int i;
    held = data;
    @(posedge ref_clk);
    cal_start <= 1'b1;
    mode <= m;
    @(posedge ref_clk);
    cal_start <= 1'b0;
    #1;
    chk(cal_busy, 1, "busy");
    chk(actl.input_short, m == adc_corr_pkg::CAL_SELF_OFFSET, "short");
    chk(actl.ref_to_input, m == adc_corr_pkg::CAL_SELF_GAIN, "ref");
    @(posedge ref_clk);
    req <= 1'b1;
    ext <= v;
    @(posedge ref_clk);
    req <= 1'b0;
    for (i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      // a conversion landing in the divide phase is dropped and never published
      req <= (i == 2);
      #1;
      if (data_valid === 1'b1) chk(1, 0, "published during cal");
      if (cal_busy === 1'b0) break;
    end
    chk(cal_busy, 0, "busy end");
    chk({8'h00, data}, {8'h00, held}, "data kept over cal");
    s = (m == adc_corr_pkg::CAL_SELF_OFFSET) ? SHORT_V :
        ((m == adc_corr_pkg::CAL_SELF_GAIN) ? REF_V : v);
    if (m[0] == 1'b0) begin
      e_off = s;
    end else begin
      d = 64'($signed(s)) - 64'($signed(e_off));
      q = (d <= 0) ? 64'hFF_FFFF : (64'sd1 <<< 46) / d;
      e_gain = (q > 64'hFF_FFFF) ? 24'hFF_FFFF : q[23:0];
    end
    chk(offset_corr, e_off, "cal offset");
    chk(gain_corr, e_gain, "cal gain");
    chk({actl.input_short, actl.ref_to_input}, 0, "switches released");
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_path();
    conv(24'h7F_FFFF);
    conv(24'h80_0000);
    conv(24'h00_0180);
    for (int a = 0; a < 4; a++) begin
      @(posedge ref_clk);
      cfg.amplifier_gain_setting <= a[1:0];
      conv(24'h01_0000);
      conv(24'h20_0000);
    end
    @(posedge ref_clk);
    cfg.amplifier_gain_setting <= 2'h0;
    cfg.unipolar <= 1'b1;
    conv(24'h01_0000);
    conv(24'hFF_0000);
    conv(24'h7F_FFFF);
    $display("path test done");
  endtask

  task automatic t_corr();
    held = data;
    wr(1'b0, 24'h00_1000);
    wr(1'b1, 24'h40_0000);
    @(posedge ref_clk);
    cfg.unipolar <= 1'b0;
    cfg.amplifier_gain_setting <= 2'h1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({8'h00, data}, {8'h00, held}, "data held");
    conv(24'h01_0000);
    conv(24'h00_0000);
    wr(1'b0, 24'hFF_F000);
    conv(24'h00_0000);
    wr(1'b1, 24'hFF_FFFF);
    conv(24'h01_0000);
    wr(1'b1, 24'h80_0000);
    wr(1'b0, 24'h00_0000);
    $display("correction test done");
  endtask

  task automatic t_cal();
    cal(adc_corr_pkg::CAL_SELF_OFFSET, 24'h12_3456);
    cal(adc_corr_pkg::CAL_SELF_GAIN, 24'h12_3456);
    conv(24'h20_0000);
    cal(adc_corr_pkg::CAL_SYS_OFFSET, 24'hFF_FF80);
    cal(adc_corr_pkg::CAL_SYS_GAIN, 24'h3F_0000);
    conv(24'h10_0000);
    $display("calibration test done");
  endtask

  task automatic t_temp();
    @(posedge ref_clk);
    cfg.positive_input_select <= 4'h7;
    cfg.negative_input_select <= 4'h0;
    @(posedge ref_clk);
    #1;
    chk(actl.temp_sensor_en, 1, "temp on");
    chk(actl.positive_input_select, 4'h7, "pos select");
    chk(actl.negative_input_select, 4'h0, "neg select");
    @(posedge ref_clk);
    cfg.positive_input_select <= 4'h6;
    @(posedge ref_clk);
    #1;
    chk(actl.temp_sensor_en, 0, "temp off");
    $display("temperature test done");
  endtask

  initial begin
    rstn = 1'b0;
    cal_start = 1'b0;
    off_wr = 1'b0;
    gain_wr = 1'b0;
    req = 1'b0;
    wdata = 24'h00_0000;
    ext = 24'h00_0000;
    mode = adc_corr_pkg::CAL_SELF_OFFSET;
    cfg = '{2'h0, 1'b0, 4'h1, 4'h2};
    e_off = 24'h00_0000;
    e_gain = 24'h80_0000;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(offset_corr, 24'h00_0000, "offset reset");
    chk(gain_corr, 24'h80_0000, "gain reset");
    chk({data_valid, cal_busy, data}, 0, "outputs reset");
    $display("reset test done");
    t_path();
    t_corr();
    t_cal();
    t_temp();
    stop_test();
  end
endmodule // adc_calibration_correction_test
`default_nettype wire
